// ---- rtl/psl_led_ctrl.sv ----
// power supply status indicators with management bus override and fru store
// Contract
// [RULE1] no ac anywhere: both indicators off
// [RULE2] critical shutdown event: amber, power-good off
// [RULE3] warning event: green, power-good off
// [RULE4] ac present, outputs off: green, power-good off
// [RULE5] outputs ok green/green; otp amber/green
// [RULE6] bus setting forces steady amber
// [RULE7] bus setting forces amber blink at 1hz
// [RULE8] no override: indicator follows supply condition
// [RULE9] override starts as none after power-on
// [RULE10] power-on request assert clears the override
// [RULE11] fru data and failure status readable
// [RULE12] clock and data are shared open-drain lines
// [RULE13] fru memory always accepts bus writes
// [RULE14] system drives request low to turn on
// [RULE15] blink from clock divider, even, starts on
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`include "psl_defines.svh"
`default_nettype none
module psl_led_ctrl #(
  parameter int BLINK_HALF_CYCLES = `PSL_BLINK_PERIOD_NS / `PSL_PCLK_PERIOD_NS / 2
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // supply condition and power-on request
  input  wire psl_pkg::psl_cond_t cond_in,
  input  wire logic              ps_on_req_n,
  // management bus pins
  input  wire logic              psu_mgmt_clock_in,
  output logic                   psu_mgmt_clock_out,
  output logic                   psu_mgmt_clock_oe_n,
  input  wire logic              psu_mgmt_data_in,
  output logic                   psu_mgmt_data_out,
  output logic                   psu_mgmt_data_oe_n,
  // indicators and interrupt
  output psl_pkg::psl_led_t      led,
  output logic                   irq
);
  import psl_pkg::*;

  function automatic psl_ovr_t ovr_decode(input logic [1:0] v);
    case (v)
      2'h1:    return PSL_OVR_AMBER;
      2'h2:    return PSL_OVR_BLINK;
      default: return PSL_OVR_NONE;
    endcase
  endfunction : ovr_decode

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [15:0] sync_q;
  psl_cond_t   cond_s;
  logic        pson_n_s;
  logic        scl_s;
  logic        sda_s;
  psl_sync2 #(.W(16), .RST(16'h0007)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({cond_in, ps_on_req_n, psu_mgmt_clock_in, psu_mgmt_data_in}),
    .q       (sync_q)
  );
  assign cond_s   = psl_cond_t'(sync_q[15:3]);
  assign pson_n_s = sync_q[2];
  assign scl_s    = sync_q[1];
  assign sda_s    = sync_q[0];

  logic pson_n_d_r;
  logic scl_d_r;
  logic sda_d_r;
  logic crit_d_r;
  logic warn_d_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pson_n_d_r <= 1'b1;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
      crit_d_r   <= 1'b0;
      warn_d_r   <= 1'b0;
    end else begin
      pson_n_d_r <= pson_n_s;
      scl_d_r    <= scl_s;
      sda_d_r    <= sda_s;
      crit_d_r   <= |cond_s.critical;
      warn_d_r   <= |cond_s.warning;
    end
  end
  logic pson_assert;
  assign pson_assert = pson_n_d_r & ~pson_n_s; // RULE14

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  logic        apb_wr;
  logic [31:0] apb_rdata;
  logic        apb_hit;
  assign apb_wr  = psel & penable & pready & pwrite;
  assign apb_hit = (paddr == `PSL_CTRL_OFS) | (paddr == `PSL_STATE_OFS) |
                   (paddr == `PSL_IRQ_STAT_OFS) | (paddr == `PSL_IRQ_MASK_OFS);

  psl_ovr_t ovr_r;
  psl_ovr_t ovr_nxt;
  logic [`PSL_IRQ_W-1:0] irq_stat_r;
  logic [`PSL_IRQ_W-1:0] irq_mask_r;

  always_comb begin
    apb_rdata = 32'h0;
    case (paddr)
      `PSL_CTRL_OFS:     apb_rdata = {30'h0, ovr_r};
      `PSL_STATE_OFS:    apb_rdata = {15'h0, ~pson_n_s, led, cond_s};
      `PSL_IRQ_STAT_OFS: apb_rdata = {27'h0, irq_stat_r};
      `PSL_IRQ_MASK_OFS: apb_rdata = {27'h0, irq_mask_r};
      default:           apb_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~apb_hit;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? apb_rdata : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // management bus slave
  // ---------------------------------------------------------------
  psl_smb_st_t smb_st_r;
  logic [7:0]  shift_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  ptr_r;
  logic        rw_r;
  logic        first_r;
  logic [7:0]  fru_mem_r [`PSL_FRU_DEPTH];
  logic [7:0]  smb_rd_byte;
  logic        scl_rise;
  logic        scl_fall;
  logic        smb_start;
  logic        smb_stop;
  logic        wbyte_done;
  logic        fru_wr;
  logic        smb_ovr_wr;

  assign scl_rise   = ~scl_d_r & scl_s;
  assign scl_fall   = scl_d_r & ~scl_s;
  assign smb_start  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign smb_stop   = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign wbyte_done = (smb_st_r == PSL_SMB_WDATA) & scl_fall & (bit_cnt_r == 4'h8) &
                      ~smb_start & ~smb_stop & ~first_r;
  assign fru_wr     = wbyte_done & (ptr_r[7:5] == 3'h0);
  assign smb_ovr_wr = wbyte_done & (ptr_r == `PSL_PTR_OVR);

  always_comb begin
    smb_rd_byte = 8'hff;
    if (ptr_r[7:5] == 3'h0) begin
      smb_rd_byte = fru_mem_r[ptr_r[4:0]]; // RULE11
    end else if (ptr_r == `PSL_PTR_OVR) begin
      smb_rd_byte = {6'h0, ovr_r};
    end else if (ptr_r == `PSL_PTR_FAIL) begin
      smb_rd_byte = {1'b0, cond_s.otp, |cond_s.warning, cond_s.critical}; // RULE11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smb_st_r           <= PSL_SMB_IDLE;
      shift_r            <= 8'h0;
      bit_cnt_r          <= 4'h0;
      ptr_r              <= `PSL_PTR_RST;
      rw_r               <= 1'b0;
      first_r            <= 1'b1;
      psu_mgmt_data_oe_n <= 1'b1;
    end else if (smb_start) begin
      smb_st_r           <= PSL_SMB_ADDR;
      bit_cnt_r          <= 4'h0;
      first_r            <= 1'b1;
      psu_mgmt_data_oe_n <= 1'b1;
    end else if (smb_stop) begin
      smb_st_r           <= PSL_SMB_IDLE;
      psu_mgmt_data_oe_n <= 1'b1;
    end else begin
      case (smb_st_r)
        PSL_SMB_ADDR, PSL_SMB_WDATA: begin
          if (scl_rise) begin
            shift_r   <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            if (smb_st_r == PSL_SMB_ADDR) begin
              if (shift_r[7:1] == `PSL_SMB_ADDR) begin
                psu_mgmt_data_oe_n <= 1'b0; // RULE12
                rw_r               <= shift_r[0];
                smb_st_r           <= PSL_SMB_ACK;
              end else begin
                smb_st_r <= PSL_SMB_IDLE;
              end
            end else begin
              psu_mgmt_data_oe_n <= 1'b0;
              smb_st_r           <= PSL_SMB_ACK;
              first_r            <= 1'b0;
              ptr_r              <= first_r ? shift_r : ptr_r + 8'h1;
            end
          end
        end
        PSL_SMB_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (rw_r) begin
              shift_r            <= smb_rd_byte;
              psu_mgmt_data_oe_n <= smb_rd_byte[7]; // RULE12
              ptr_r              <= ptr_r + 8'h1;
              smb_st_r           <= PSL_SMB_RDATA;
            end else begin
              psu_mgmt_data_oe_n <= 1'b1;
              smb_st_r           <= PSL_SMB_WDATA;
            end
          end
        end
        PSL_SMB_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_r == 4'h7) begin
              psu_mgmt_data_oe_n <= 1'b1;
              smb_st_r           <= PSL_SMB_RACK;
            end else begin
              bit_cnt_r          <= bit_cnt_r + 4'h1;
              shift_r            <= {shift_r[6:0], 1'b0};
              psu_mgmt_data_oe_n <= shift_r[6];
            end
          end
        end
        PSL_SMB_RACK: begin
          if (scl_rise) begin
            smb_st_r <= sda_s ? PSL_SMB_IDLE : PSL_SMB_ACK;
          end
        end
        default: smb_st_r <= PSL_SMB_IDLE;
      endcase
    end
  end

  // clock line is never stretched; data line only ever pulled low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psu_mgmt_clock_out  <= 1'b0;
      psu_mgmt_clock_oe_n <= 1'b1;
      psu_mgmt_data_out   <= 1'b0;
    end else begin
      psu_mgmt_clock_out  <= 1'b0;
      psu_mgmt_clock_oe_n <= 1'b1; // RULE12
      psu_mgmt_data_out   <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `PSL_FRU_DEPTH; i++) begin
        fru_mem_r[i] <= 8'h0;
      end
    end else if (fru_wr) begin
      fru_mem_r[ptr_r[4:0]] <= shift_r; // RULE13
    end
  end

  // ---------------------------------------------------------------
  // override setting and blink
  // ---------------------------------------------------------------
  always_comb begin
    ovr_nxt = ovr_r;
    if (pson_assert) begin
      ovr_nxt = PSL_OVR_NONE; // RULE10
    end else if (apb_wr && paddr == `PSL_CTRL_OFS) begin
      ovr_nxt = ovr_decode(pwdata[1:0]);
    end else if (smb_ovr_wr) begin
      ovr_nxt = ovr_decode(shift_r[1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_r <= PSL_OVR_NONE; // RULE9
    end else begin
      ovr_r <= ovr_nxt;
    end
  end

  logic blink_phase;
  psl_blink #(.HALF(BLINK_HALF_CYCLES)) u_blink (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (ovr_nxt == PSL_OVR_BLINK && ovr_r != PSL_OVR_BLINK), // RULE15
    .phase   (blink_phase)
  );

  // ---------------------------------------------------------------
  // condition to indicator mapping
  // ---------------------------------------------------------------
  psl_led_t led_nxt;
  always_comb begin
    led_nxt = '0;
    if (!cond_s.ac_present) begin
      led_nxt = '0; // RULE1
    end else begin
      if (|cond_s.critical) begin
        led_nxt.fault_amber = 1'b1; // RULE2
      end else if (cond_s.otp) begin
        led_nxt.fault_amber = 1'b1; // RULE5
        led_nxt.pwr_good    = 1'b1;
      end else if (|cond_s.warning) begin
        led_nxt.fault_green = 1'b1; // RULE3
      end else if (!(cond_s.outputs_on && cond_s.outputs_ok)) begin
        led_nxt.fault_green = 1'b1; // RULE4
      end else begin
        led_nxt.fault_green = 1'b1; // RULE5
        led_nxt.pwr_good    = 1'b1;
      end
      case (ovr_r)
        PSL_OVR_AMBER: begin
          led_nxt.fault_green = 1'b0; // RULE6
          led_nxt.fault_amber = 1'b1;
        end
        PSL_OVR_BLINK: begin
          led_nxt.fault_green = 1'b0; // RULE7
          led_nxt.fault_amber = blink_phase;
        end
        default: ; // RULE8
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led <= '0;
    end else begin
      led <= led_nxt;
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  logic [`PSL_IRQ_W-1:0] irq_ev;
  logic [`PSL_IRQ_W-1:0] irq_clr;
  always_comb begin
    irq_ev                   = '0;
    irq_ev[`PSL_IRQ_CRIT]    = (|cond_s.critical) & ~crit_d_r;
    irq_ev[`PSL_IRQ_WARN]    = (|cond_s.warning) & ~warn_d_r;
    irq_ev[`PSL_IRQ_OVR_SMB] = smb_ovr_wr;
    irq_ev[`PSL_IRQ_FRU_WR]  = fru_wr;
    irq_ev[`PSL_IRQ_PSON]    = pson_assert;
    irq_clr = (apb_wr && paddr == `PSL_IRQ_STAT_OFS) ? pwdata[`PSL_IRQ_W-1:0] : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= `PSL_IRQ_STAT_RST;
      irq_mask_r <= `PSL_IRQ_MASK_RST;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      if (apb_wr && paddr == `PSL_IRQ_MASK_OFS) begin
        irq_mask_r <= pwdata[`PSL_IRQ_W-1:0];
      end
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic clean;
  assign clean = cond_s.ac_present & ~(|cond_s.critical) & ~cond_s.otp & ~(|cond_s.warning);

  sequence seq_pson_edge;
    pson_n_s ##1 !pson_n_s;
  endsequence
  sequence seq_blink_enter;
    ovr_r != PSL_OVR_BLINK ##1 ovr_r == PSL_OVR_BLINK && cond_s.ac_present;
  endsequence

  chk_pson_clears_ovr: assert property (seq_pson_edge |=> ovr_r == PSL_OVR_NONE) // RULE10
    else $error("override not cleared on power-on request");
  chk_no_ac_dark: assert property (!cond_s.ac_present |=> led == 3'h0) // RULE1
    else $error("indicators lit without ac");
  chk_crit_amber: assert property (cond_s.ac_present && |cond_s.critical && // RULE2
      ovr_r == PSL_OVR_NONE |=> led == 3'h2)
    else $error("critical event not amber");
  chk_warn_green: assert property (cond_s.ac_present && !(|cond_s.critical) && // RULE3
      !cond_s.otp && |cond_s.warning && ovr_r == PSL_OVR_NONE |=> led == 3'h4)
    else $error("warning event not green");
  chk_standby_green: assert property (clean && !cond_s.outputs_on && // RULE4
      ovr_r == PSL_OVR_NONE |=> led == 3'h4)
    else $error("standby state wrong");
  chk_ok_both_green: assert property (clean && cond_s.outputs_on && cond_s.outputs_ok && // RULE5
      ovr_r == PSL_OVR_NONE |=> led == 3'h5)
    else $error("outputs ok not green");
  chk_otp_amber_pg: assert property (cond_s.ac_present && !(|cond_s.critical) && // RULE5
      cond_s.otp && ovr_r == PSL_OVR_NONE |=> led == 3'h3)
    else $error("otp state wrong");
  chk_force_amber: assert property (cond_s.ac_present && ovr_r == PSL_OVR_AMBER // RULE6
      |=> led.fault_amber && !led.fault_green)
    else $error("forced amber not shown");
  chk_blink_starts_on: assert property (seq_blink_enter |-> blink_phase [*8] // RULE15
      ##0 led.fault_amber)
    else $error("blink did not start on");
  chk_fru_store: assert property (fru_wr |=> fru_mem_r[$past(ptr_r[4:0])] == $past(shift_r)) // RULE13
    else $error("fru byte not stored");
  chk_smb_addr_ack: assert property (smb_st_r == PSL_SMB_ADDR && scl_fall && // RULE12
      bit_cnt_r == 4'h8 && shift_r[7:1] == `PSL_SMB_ADDR && !smb_start && !smb_stop
      |=> !psu_mgmt_data_oe_n && smb_st_r == PSL_SMB_ACK)
    else $error("address not acknowledged");
endmodule : psl_led_ctrl
`default_nettype wire

// ---- rtl/psl_defines.svh ----
// register offsets, field positions, reset values and timing of the status indicator block
`ifndef PSL_DEFINES_SVH
`define PSL_DEFINES_SVH
// ---------------------------------------------------------------
// apb register map
// ---------------------------------------------------------------
`define PSL_CTRL_OFS        8'h00
`define PSL_STATE_OFS       8'h04
`define PSL_IRQ_STAT_OFS    8'h08
`define PSL_IRQ_MASK_OFS    8'h0c
// ---------------------------------------------------------------
// interrupt bit positions and reset values
// ---------------------------------------------------------------
`define PSL_IRQ_CRIT        0
`define PSL_IRQ_WARN        1
`define PSL_IRQ_OVR_SMB     2
`define PSL_IRQ_FRU_WR      3
`define PSL_IRQ_PSON        4
`define PSL_IRQ_W           5
`define PSL_IRQ_STAT_RST    5'h00
`define PSL_IRQ_MASK_RST    5'h00
// ---------------------------------------------------------------
// management bus map
// ---------------------------------------------------------------
`define PSL_SMB_ADDR        7'h58
`define PSL_FRU_DEPTH       32
`define PSL_PTR_OVR         8'h20
`define PSL_PTR_FAIL        8'h21
`define PSL_PTR_RST         8'h00
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PSL_PCLK_PERIOD_NS  100
`define PSL_BLINK_PERIOD_NS 1000000000
`endif

// ---- rtl/psl_pkg.sv ----
// types shared by the status indicator block
`default_nettype none
package psl_pkg;
  typedef enum logic [1:0] {PSL_OVR_NONE, PSL_OVR_AMBER, PSL_OVR_BLINK} psl_ovr_t;
  typedef struct packed {
    logic       ac_present;
    logic       outputs_on;
    logic       outputs_ok;
    logic       otp;
    logic [4:0] critical;
    logic [3:0] warning;
  } psl_cond_t;
  typedef struct packed {
    logic fault_green;
    logic fault_amber;
    logic pwr_good;
  } psl_led_t;
  typedef enum logic [2:0] {
    PSL_SMB_IDLE, PSL_SMB_ADDR, PSL_SMB_ACK, PSL_SMB_WDATA, PSL_SMB_RDATA, PSL_SMB_RACK
  } psl_smb_st_t;
endpackage : psl_pkg
`default_nettype wire

// ---- rtl/psl_sync2.sv ----
// two flip-flop synchroniser for pins from outside the clock domain
`default_nettype none
module psl_sync2 #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= RST;
      q      <= RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : psl_sync2
`default_nettype wire

// ---- rtl/psl_blink.sv ----
// divider that makes the forced blink phase
`default_nettype none
module psl_blink #(
  parameter int HALF = 5000000
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic restart,
  output logic      phase
);
  logic [22:0] cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 23'h0;
      phase <= 1'b1;
    end else if (restart) begin
      cnt_r <= 23'h0;
      phase <= 1'b1;
    end else if (cnt_r == 23'(HALF - 1)) begin
      cnt_r <= 23'h0;
      phase <= ~phase;
    end else begin
      cnt_r <= cnt_r + 23'h1;
    end
  end
endmodule : psl_blink
`default_nettype wire

// ---- dv/psl_smb_host.sv ----
// smbus controller model standing for the board management side
`default_nettype none
module psl_smb_host (
  // clock
  input  wire logic pclk,
  // resolved bus lines
  input  wire logic scl,
  input  wire logic sda,
  // open-drain enables, low pulls the line
  output logic      scl_oe_n,
  output logic      sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // released lines idle high, clock still between frames
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // data moves mid-low, sampled mid-high; low 5, high 3 cycles
  task automatic bit_io(input logic b, output logic s);
    cyc(2);
    sda_oe_n <= b;
    cyc(3);
    scl_oe_n <= 1'b1;
    cyc(2);
    s = sda;
    cyc(1);
    scl_oe_n <= 1'b0;
  endtask : bit_io
  task automatic start();
    cyc(2);
    sda_oe_n <= 1'b1;
    cyc(2);
    scl_oe_n <= 1'b1;
    cyc(3);
    sda_oe_n <= 1'b0;
    cyc(3);
    scl_oe_n <= 1'b0;
  endtask : start
  task automatic stop();
    cyc(2);
    sda_oe_n <= 1'b0;
    cyc(2);
    scl_oe_n <= 1'b1;
    cyc(3);
    sda_oe_n <= 1'b1;
    cyc(3);
  endtask : stop
  task automatic wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wr
  // last byte answered with nack
  task automatic rd(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask : rd
endmodule : psl_smb_host
`default_nettype wire

// ---- dv/tb_psu_status_led_control.sv ----
// self-checking bench of the status indicator block
`include "psl_defines.svh"
`default_nettype none
module tb_psu_status_led_control;
  timeunit 1ns;
  timeprecision 1ns;
  import psl_pkg::*;
  localparam int HALF = 16;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        perr, ack, ps_on_req_n, d_scl_oe_n, d_sda_oe_n, m_scl_oe_n, m_sda_oe_n;
  logic [7:0]  d;
  logic        d_scl_o, d_sda_o;
  psl_cond_t   cond;
  psl_led_t    led;
  int          n_fail = 0;
  int          checks = 0;
  wire scl = m_scl_oe_n & d_scl_oe_n;
  wire sda = m_sda_oe_n & d_sda_oe_n;

  psl_led_ctrl #(.BLINK_HALF_CYCLES(HALF)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cond_in(cond), .ps_on_req_n(ps_on_req_n),
    .psu_mgmt_clock_in(scl), .psu_mgmt_clock_out(d_scl_o), .psu_mgmt_clock_oe_n(d_scl_oe_n),
    .psu_mgmt_data_in(sda), .psu_mgmt_data_out(d_sda_o), .psu_mgmt_data_oe_n(d_sda_oe_n),
    .led(led), .irq(irq));
  psl_smb_host h (.pclk(pclk), .scl(scl), .sda(sda), .scl_oe_n(m_scl_oe_n),
    .sda_oe_n(m_sda_oe_n));

  always #50 pclk = ~pclk;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat    = prdata;
    perr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic conclude();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk(led, 3'b000);
    chk({irq, d_scl_oe_n, d_sda_oe_n}, 3'b011);
    presetn <= 1'b1;
    apb(1'b0, `PSL_CTRL_OFS, 32'h0);
    chk(rdat, 32'h0);
  endtask : t_reset
  task automatic t_map();
    logic [12:0] c [7] = '{13'h0000, 13'h1010, 13'h1c01, 13'h1000, 13'h1c00, 13'h1e00,
                           13'h1c10};
    logic [2:0]  e [7] = '{3'b000, 3'b010, 3'b100, 3'b100, 3'b101, 3'b011, 3'b010};
    for (int i = 0; i < 7; i++) begin
      cond <= c[i];
      cyc(5);
      chk(led, e[i]);
    end
  endtask : t_map
  task automatic t_apb_ovr();
    int n;
    n = 0;
    cond <= 13'h1c00;
    apb(1'b1, `PSL_CTRL_OFS, 32'h1);
    cyc(4);
    chk(led, 3'b011);
    apb(1'b1, `PSL_CTRL_OFS, 32'h2);
    cyc(3);
    chk(led, 3'b011);
    repeat (4 * HALF) begin
      @(posedge pclk);
      n += led.fault_amber;
    end
    chk(n, 2 * HALF);
    apb(1'b1, `PSL_CTRL_OFS, 32'h3);
    apb(1'b0, `PSL_CTRL_OFS, 32'h0);
    chk(rdat, 32'h0);
    chk(led, 3'b101);
    apb(1'b1, `PSL_CTRL_OFS, 32'h1);
    cond <= 13'h0000;
    cyc(5);
    chk(led, 3'b000);
    cond <= 13'h1c00;
    cyc(5);
  endtask : t_apb_ovr
  task automatic t_pson();
    apb(1'b1, `PSL_IRQ_STAT_OFS, 32'h1f);
    ps_on_req_n <= 1'b0;
    cyc(6);
    apb(1'b0, `PSL_CTRL_OFS, 32'h0);
    chk(rdat, 32'h0);
    chk(led, 3'b101);
    apb(1'b0, `PSL_STATE_OFS, 32'h0);
    chk(rdat, 32'h0001bc00);
    chk(perr, 1'b0);
    apb(1'b0, `PSL_IRQ_STAT_OFS, 32'h0);
    chk(rdat, 32'h10);
    chk(irq, 1'b0);
    apb(1'b1, `PSL_IRQ_MASK_OFS, 32'h10);
    cyc(3);
    chk(irq, 1'b1);
    apb(1'b1, `PSL_IRQ_STAT_OFS, 32'h10);
    cyc(3);
    chk(irq, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    chk(perr, 1'b1);
    chk(rdat, 32'h0);
  endtask : t_pson
  task automatic t_smb();
    cond <= 13'h1c01;
    h.start();
    h.wr(8'hb0, ack);
    chk(ack, 1'b1);
    h.wr(8'h05, ack);
    h.wr(8'ha5, ack);
    h.wr(8'h3c, ack);
    chk(ack, 1'b1);
    h.start();
    h.wr(8'hb0, ack);
    h.wr(8'h05, ack);
    h.start();
    h.wr(8'hb1, ack);
    h.rd(1'b0, d);
    chk(d, 8'ha5);
    h.rd(1'b1, d);
    chk(d, 8'h3c);
    h.start();
    h.wr(8'hb0, ack);
    h.wr(`PSL_PTR_FAIL, ack);
    h.start();
    h.wr(8'hb1, ack);
    h.rd(1'b1, d);
    chk(d, 8'h20);
    h.start();
    h.wr(8'hb0, ack);
    h.wr(`PSL_PTR_OVR, ack);
    h.wr(8'h01, ack);
    h.stop();
    cyc(5);
    chk(led, 3'b010);
    h.start();
    h.wr(8'h42, ack);
    chk(ack, 1'b0);
    h.stop();
    chk({d_scl_o, d_sda_o, d_scl_oe_n}, 3'b001);
    apb(1'b0, `PSL_IRQ_STAT_OFS, 32'h0);
    chk(rdat, 32'h0000000e);
  endtask : t_smb

  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    cond        = '0;
    ps_on_req_n = 1'b1;
    cyc(3);
    t_reset();
    t_map();
    t_apb_ovr();
    t_pson();
    t_smb();
    conclude();
  end
  initial begin
    #2_000_000;
    n_fail++;
    conclude();
  end
endmodule : tb_psu_status_led_control
`default_nettype wire
